// File: shared/irq_route_defs.svh
`ifndef IRQ_ROUTE_DEFS_SVH
`define IRQ_ROUTE_DEFS_SVH

// Register offsets
`define ADDR_EMB_ROUTE_A   8'h0A
`define ADDR_SM_LOW_A      8'h0B
`define ADDR_SM_HIGH_A     8'h0C
`define ADDR_LEARN_A       8'h0D
`define ADDR_EMB_ROUTE_B   8'h0E
`define ADDR_SM_LOW_B      8'h0F
`define ADDR_SM_HIGH_B     8'h10
`define ADDR_LEARN_B       8'h11
`define ADDR_EMB_STATUS    8'h12
`define ADDR_SM_LOW_STAT   8'h13
`define ADDR_SM_HIGH_STAT  8'h14
`define ADDR_LATCH_CTRL    8'h17
`define ADDR_PIN_A_CFG     8'h5E
`define ADDR_PIN_B_CFG     8'h5F

// Storage slots of the writable registers
`define SLOT_EMB_ROUTE_A   4'h0
`define SLOT_SM_LOW_A      4'h1
`define SLOT_SM_HIGH_A     4'h2
`define SLOT_LEARN_A       4'h3
`define SLOT_EMB_ROUTE_B   4'h4
`define SLOT_SM_LOW_B      4'h5
`define SLOT_SM_HIGH_B     4'h6
`define SLOT_LEARN_B       4'h7
`define SLOT_LATCH_CTRL    4'h8
`define SLOT_PIN_A_CFG     4'h9
`define SLOT_PIN_B_CFG     4'hA
`define SLOT_COUNT         11

// Field positions
`define LONG_COUNT_BIT     7
`define LATCH_MODE_BIT     7
`define GATE_BIT           1

// Writable bit masks and reset value
`define MASK_FULL          8'hFF
`define MASK_TOP_BIT       8'h80
`define MASK_GATE          8'h02
`define REG_RESET          8'h00

`endif

// File: shared/irq_route_pkg.sv
`include "irq_route_defs.svh"

package irq_route_pkg;

    // Register port request from software
    typedef struct packed {
        logic [7:0] addr;       // Register offset
        logic [7:0] wdata;      // Write data
        logic       wr;         // Write strobe
        logic       rd;         // Read strobe
    } reg_req_t;

    // Event levels from the embedded engines
    typedef struct packed {
        logic [15:0] sm;        // State machine events, bit 0 is machine one
        logic [7:0]  learn;     // Learning core events, bit 0 is event one
        logic        long_count; // Long-count timeout
    } evt_bus_t;

    // Decoded slot lookup
    typedef struct packed {
        logic       hit;        // Address names a writable register
        logic [3:0] slot;       // Storage slot
    } slot_hit_t;

endpackage : irq_route_pkg

// File: rtl/route_reg_bank.sv
`include "irq_route_defs.svh"

module route_reg_bank
    import irq_route_pkg::*;
#(
    parameter int NSLOTS = `SLOT_COUNT,
    parameter int W      = 8
) (
    input  wire logic                    clk,     // System clock
    input  wire logic                    rst,     // Synchronous reset
    input  wire logic                    wr_en,   // Write one slot
    input  wire logic [3:0]              wr_slot, // Slot being written
    input  wire logic [W-1:0]            wr_data, // Masked write data
    output logic      [NSLOTS-1:0][W-1:0] q       // Stored contents
);

    ////////////////////////////////////////////////////////////////////
    // Storage: every slot clears to zero so nothing is routed
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else if (wr_en && (32'(wr_slot) < NSLOTS)) begin
            q[wr_slot] <= wr_data;
        end
    end

endmodule : route_reg_bank

// File: rtl/irq_event_router.sv
// Chosen here: strobed register access.
`include "irq_route_defs.svh"

module irq_event_router
    import irq_route_pkg::*;
(
    input  wire logic       clk,       // System clock, 20 MHz
    input  wire logic       rst,       // Synchronous reset, active high
    input  wire reg_req_t   req,       // Register port request
    input  wire evt_bus_t   evt,       // Event levels from the engines
    output logic      [7:0] rdata,     // Read data, cycle after read
    output logic            irq_out_a, // First interrupt pin
    output logic            irq_out_b  // Second interrupt pin
);

    ////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Map a register offset to its storage slot
    function automatic slot_hit_t slot_of(input logic [7:0] a);
        slot_hit_t s;
        s = '{hit: 1'b1, slot: 4'h0};
        unique case (a)
            `ADDR_EMB_ROUTE_A: s.slot = `SLOT_EMB_ROUTE_A;
            `ADDR_SM_LOW_A:    s.slot = `SLOT_SM_LOW_A;
            `ADDR_SM_HIGH_A:   s.slot = `SLOT_SM_HIGH_A;
            `ADDR_LEARN_A:     s.slot = `SLOT_LEARN_A;
            `ADDR_EMB_ROUTE_B: s.slot = `SLOT_EMB_ROUTE_B;
            `ADDR_SM_LOW_B:    s.slot = `SLOT_SM_LOW_B;
            `ADDR_SM_HIGH_B:   s.slot = `SLOT_SM_HIGH_B;
            `ADDR_LEARN_B:     s.slot = `SLOT_LEARN_B;
            `ADDR_LATCH_CTRL:  s.slot = `SLOT_LATCH_CTRL;
            `ADDR_PIN_A_CFG:   s.slot = `SLOT_PIN_A_CFG;
            `ADDR_PIN_B_CFG:   s.slot = `SLOT_PIN_B_CFG;
            // Status and unmapped offsets hold nothing writable
            default:           s.hit  = 1'b0;
        endcase
        return s;
    endfunction : slot_of

    // Bits of a slot that really store; the rest read as zero
    function automatic logic [7:0] mask_of(input logic [3:0] s);
        logic [7:0] m;
        m = `MASK_FULL;
        unique case (s)
            `SLOT_EMB_ROUTE_A: m = `MASK_TOP_BIT;
            `SLOT_EMB_ROUTE_B: m = `MASK_TOP_BIT;
            `SLOT_LATCH_CTRL:  m = `MASK_TOP_BIT;
            `SLOT_PIN_A_CFG:   m = `MASK_GATE;
            `SLOT_PIN_B_CFG:   m = `MASK_GATE;
            default:           m = `MASK_FULL;
        endcase
        return m;
    endfunction : mask_of

    ////////////////////////////////////////////////////////////////////
    // Declarations

    slot_hit_t                      wr_hit;    // Decode of write address
    logic                           bank_wr;   // Write into the bank
    logic [7:0]                     bank_data; // Masked write data
    logic [`SLOT_COUNT-1:0][7:0]    cfg;       // Stored registers

    logic [15:0] route_sm_a;    // Machine routes to pin A
    logic        route_lc_a;    // Timeout route to pin A
    logic [7:0]  route_learn_a; // Learning routes to pin A
    logic [15:0] route_sm_b;    // Machine routes to pin B
    logic        route_lc_b;    // Timeout route to pin B
    logic [7:0]  route_learn_b; // Learning routes to pin B
    logic        latch_mode;    // Embedded requests latched
    logic        gate_a;        // Embedded routes to pin A enabled
    logic        gate_b;        // Embedded routes to pin B enabled

    logic [15:0] sm_status;     // Machine event status
    logic        lc_status;     // Timeout event status
    logic [7:0]  learn_level;   // Registered learning events
    logic [15:0] next_sm_status; // Next machine status
    logic        next_lc_status; // Next timeout status
    logic [15:0] sm_clear;      // Status bits cleared by a read
    logic        lc_clear;      // Timeout cleared by a read
    logic        next_irq_a;    // Next pin A level
    logic        next_irq_b;    // Next pin B level
    logic [7:0]  next_rdata;    // Next read data

    ////////////////////////////////////////////////////////////////////
    // Register writes

    // Only writable offsets reach the bank; status writes drop here
    always_comb begin
        wr_hit    = slot_of(req.addr);
        bank_wr   = req.wr && wr_hit.hit;
        // Reserved bits are forced to zero whatever the host sends
        bank_data = req.wdata & mask_of(wr_hit.slot);
    end

    // Storage for routing, latch and gate registers
    route_reg_bank #(
        .NSLOTS (`SLOT_COUNT),
        .W      (8)
    ) u_bank (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (bank_wr),
        .wr_slot (wr_hit.slot),
        .wr_data (bank_data),
        .q       (cfg)
    );

    ////////////////////////////////////////////////////////////////////
    // Field extraction

    // Pull routing fields out of the stored bytes
    always_comb begin
        route_lc_a    = cfg[`SLOT_EMB_ROUTE_A][`LONG_COUNT_BIT];
        route_sm_a    = {cfg[`SLOT_SM_HIGH_A], cfg[`SLOT_SM_LOW_A]};
        route_learn_a = cfg[`SLOT_LEARN_A];
        route_lc_b    = cfg[`SLOT_EMB_ROUTE_B][`LONG_COUNT_BIT];
        route_sm_b    = {cfg[`SLOT_SM_HIGH_B],
                         cfg[`SLOT_SM_LOW_B]};
        route_learn_b = cfg[`SLOT_LEARN_B];
        latch_mode    = cfg[`SLOT_LATCH_CTRL][`LATCH_MODE_BIT];
        gate_a        = cfg[`SLOT_PIN_A_CFG][`GATE_BIT];
        gate_b        = cfg[`SLOT_PIN_B_CFG][`GATE_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Event status

    // Reading a status register in latched mode clears what it showed
    always_comb begin
        sm_clear = '0;
        lc_clear = 1'b0;
        if (req.rd) begin
            unique case (req.addr)
                `ADDR_SM_LOW_STAT:  sm_clear[7:0]  = 8'hFF;
                `ADDR_SM_HIGH_STAT: sm_clear[15:8] = 8'hFF;
                `ADDR_EMB_STATUS:   lc_clear       = 1'b1;
                default:            lc_clear       = 1'b0;
            endcase
        end
    end

    // Unlatched follows the event; latched holds until read.
    // A new event in the clearing cycle wins over the clear.
    always_comb begin
        if (latch_mode) begin
            next_sm_status = evt.sm | (sm_status & ~sm_clear);
            next_lc_status = evt.long_count | (lc_status & ~lc_clear);
        end else begin
            next_sm_status = evt.sm;
            next_lc_status = evt.long_count;
        end
    end

    // Status flops for machines and long-count timeout
    always_ff @(posedge clk) begin
        if (rst) begin
            sm_status <= 16'h0000;
            lc_status <= 1'b0;
        end else begin
            sm_status <= next_sm_status;
            lc_status <= next_lc_status;
        end
    end

    // Learning events are registered to line up with the status path
    always_ff @(posedge clk) begin
        if (rst) begin
            learn_level <= 8'h00;
        end else begin
            learn_level <= evt.learn;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin routing

    // Each pin ORs its selected sources; embedded ones need the gate
    always_comb begin
        next_irq_a = (|(learn_level & route_learn_a))
                   | (gate_a & ((|(sm_status & route_sm_a))
                   | (lc_status & route_lc_a)));
        next_irq_b = (|(learn_level & route_learn_b))
                   | (gate_b & ((|(sm_status & route_sm_b))
                   | (lc_status & route_lc_b)));
    end

    // Pin flops, low from reset until something is routed
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_out_a <= 1'b0;
            irq_out_b <= 1'b0;
        end else begin
            irq_out_a <= next_irq_a;
            irq_out_b <= next_irq_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register reads

    // Read mux; status shows the value before any clear
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `ADDR_EMB_STATUS:   next_rdata = {lc_status, 7'h00};
                `ADDR_SM_LOW_STAT:  next_rdata = sm_status[7:0];
                `ADDR_SM_HIGH_STAT: next_rdata = sm_status[15:8];
                default: begin
                    // Writable registers read back; unmapped read zero
                    if (slot_of(req.addr).hit) begin
                        next_rdata = cfg[slot_of(req.addr).slot];
                    end else begin
                        next_rdata = 8'h00;
                    end
                end
            endcase
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule : irq_event_router

// File: tb/irq_event_router_properties.sv
module irq_event_router_checker
    import irq_route_pkg::*;
(
    input wire logic       clk,       // Clock
    input wire logic       rst,       // Reset
    input wire reg_req_t   req,       // Register port
    input wire evt_bus_t   evt,       // Event levels
    input wire logic [7:0] rdata,     // Read data
    input wire logic       irq_out_a, // First pin
    input wire logic       irq_out_b  // Second pin
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    logic [7:0] lrn_a;  // Learning route shadow, pin A
    logic [7:0] lrn_b;  // Learning route shadow, pin B
    logic       gate_a; // Gate shadow, pin A
    logic       gate_b; // Gate shadow, pin B

    // Shadow the host writes that steer the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            lrn_a  <= 8'h00;
            lrn_b  <= 8'h00;
            gate_a <= 1'b0;
            gate_b <= 1'b0;
        end else if (req.wr) begin
            if (req.addr == 8'h0D) lrn_a <= req.wdata;
            if (req.addr == 8'h11) lrn_b <= req.wdata;
            if (req.addr == 8'h5E) gate_a <= req.wdata[1];
            if (req.addr == 8'h5F) gate_b <= req.wdata[1];
        end
    end
    ////////////////////////////////////////////////////////////
    property p_reset_quiet;
        $fell(rst) |-> !irq_out_a && !irq_out_b && rdata == 8'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
    property p_rdata_idle;
        !req.rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");
    property p_reserved_zero;
        req.rd && (req.addr == 8'h0E || req.addr == 8'h12)
            |=> rdata[6:0] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");
    property p_route_a_read;
        req.rd && req.addr == 8'h0D |=> rdata == lrn_a;
    endproperty
    a_route_a_read: assert property (p_route_a_read)
        else $error("pin A learning route readback wrong");
    property p_pin_a_learn;
        !$past(rst) && |($past(evt.learn, 2) & $past(lrn_a)) |-> irq_out_a;
    endproperty
    a_pin_a_learn: assert property (p_pin_a_learn)
        else $error("routed learning event missing on pin A");
    property p_pin_b_learn;
        !$past(rst) && |($past(evt.learn, 2) & $past(lrn_b)) |-> irq_out_b;
    endproperty
    a_pin_b_learn: assert property (p_pin_b_learn)
        else $error("routed learning event missing on pin B");
    property p_gate_a_off;
        !$past(gate_a) && !(|($past(evt.learn, 2) & $past(lrn_a)))
            |-> !irq_out_a;
    endproperty
    a_gate_a_off: assert property (p_gate_a_off)
        else $error("pin A high with gate closed");
    property p_gate_b_off;
        !$past(gate_b) && !(|($past(evt.learn, 2) & $past(lrn_b)))
            |-> !irq_out_b;
    endproperty
    a_gate_b_off: assert property (p_gate_b_off)
        else $error("pin B high with gate closed");
endmodule : irq_event_router_checker

bind irq_event_router irq_event_router_checker irq_event_router_checker_i (
    .clk(clk), .rst(rst), .req(req), .evt(evt), .rdata(rdata),
    .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));

// File: tb/event_source.sv
module event_source
    import irq_route_pkg::*;
(
    input  wire logic     clk,      // Clock
    input  wire logic     rst,      // Reset
    input  wire evt_bus_t next_evt, // Levels asked by the bench
    output evt_bus_t      evt       // Levels seen by the router
);
    timeunit 1ns;
    timeprecision 1ns;
    // Engines go quiet in reset and change only on clock edges
    always_ff @(posedge clk) begin
        if (rst) evt <= '0;
        else evt <= next_evt;
    end
endmodule : event_source

// File: tb/embedded_event_irq_routing_tb_top.sv
module embedded_event_irq_routing_tb_top
    import irq_route_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0; // Clock
    logic       rst = 1'b1; // Reset
    reg_req_t   req = '0;   // Register request
    evt_bus_t   ev  = '0;   // Requested events
    evt_bus_t   evt;        // Events at the router
    logic [7:0] rdata;      // Read data
    logic       irq_a;      // First pin
    logic       irq_b;      // Second pin
    logic [15:0] m;         // Machine bit under test
    int err_total = 0;      // Mismatches
    int cmp_count = 0;      // Comparisons
    int cycles = 0;         // Run length
    logic [7:0] regs [14] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h17, 8'h5E, 8'h5F};
    logic [7:0] rw [4] = '{8'h0D, 8'h0F, 8'h10, 8'h11};

    always #25 clk = ~clk;

    event_source event_source_i (.clk(clk), .rst(rst), .next_evt(ev),
        .evt(evt));
    irq_event_router irq_event_router_i (.clk(clk), .rst(rst), .req(req),
        .evt(evt), .rdata(rdata), .irq_out_a(irq_a), .irq_out_b(irq_b));

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp, "rdata");
    endtask : rd

    // Let events cross the source and the router, then look at the pins
    task automatic pins(input logic ea, input logic eb);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({6'h00, irq_a, irq_b}, {6'h00, ea, eb}, "pins");
    endtask : pins

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin : main
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[k]) rd(regs[k], 8'h00);
        foreach (rw[k]) wr(rw[k], rw[k] ^ 8'hA5);
        foreach (rw[k]) rd(rw[k], rw[k] ^ 8'hA5);
        wr(8'h0E, 8'h80);
        rd(8'h0E, 8'h80);
        for (int a = 8'h12; a < 8'h15; a++) wr(a[7:0], 8'hFF);
        for (int a = 8'h12; a < 8'h15; a++) rd(a[7:0], 8'h00);
        rd(8'h20, 8'h00);
        // Each learning event alone on both pins, then all the others
        for (int i = 0; i < 8; i++) begin
            wr(8'h0D, 8'h01 << i);
            wr(8'h11, 8'h01 << i);
            ev.learn <= 8'h01 << i;
            pins(1'b1, 1'b1);
            ev.learn <= ~(8'h01 << i);
            pins(1'b0, 1'b0);
        end
        ev.learn <= 8'h00;
        foreach (regs[k]) if (k < 8) wr(regs[k], 8'hFF);
        ev.sm <= 16'hFFFF;
        ev.long_count <= 1'b1;
        pins(1'b0, 1'b0);
        wr(8'h5E, 8'h02);
        wr(8'h5F, 8'h02);
        pins(1'b1, 1'b1);
        rd(8'h12, 8'h80);
        ev.long_count <= 1'b0;
        // One machine at a time: routed to pin B, the rest to pin A
        for (int i = 0; i < 16; i++) begin
            m = 16'h0001 << i;
            wr(8'h0B, ~m[7:0]);
            wr(8'h0C, ~m[15:8]);
            wr(8'h0F, m[7:0]);
            wr(8'h10, m[15:8]);
            ev.sm <= m;
            pins(1'b0, 1'b1);
            rd(8'h13, m[7:0]);
            rd(8'h14, m[15:8]);
        end
        // Latched mode keeps a short event until its status is read
        ev.sm <= 16'h0000;
        wr(8'h17, 8'h80);
        rd(8'h13, 8'h00);
        ev.sm <= 16'h0001;
        @(posedge clk);
        ev.sm <= 16'h0000;
        repeat (4) @(posedge clk);
        rd(8'h13, 8'h01);
        rd(8'h13, 8'h00);
        end_of_test();
    end
endmodule : embedded_event_irq_routing_tb_top
